// ==== hdl/icr_top.sv ====
// Input path configuration register with AXI4-Lite access and interrupts
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module icr_top
  import icr_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [ICR_AW-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [ICR_DW-1:0]     s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ICR_AW-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [ICR_DW-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Interrupt
  output logic                       irq,
  // Device context
  input  wire logic                  die_id_enable,
  input  wire logic                  full_word_interface,
  input  wire logic                  alarm_request,
  // Alarm pin, three signals
  input  wire logic                  alarm_pin_i,
  output logic                       alarm_pin_o,
  output logic                       alarm_pin_oe_n,
  // Input data path
  input  wire logic [ICR_WORD_W-1:0] input_word,
  input  wire logic                  input_word_valid,
  output logic      [ICR_WORD_W-1:0] shaped_sample,
  output logic                       shaped_sample_valid,
  // Control levels
  output icr_ctrl_t                  ctrl
);

  // Whole module state
  typedef struct packed {
    logic [ICR_CFG_W-1:0] cfg;
    logic [ICR_EV_N-1:0]  irq_status;
    logic [ICR_EV_N-1:0]  irq_mask;
    logic                 aw_held;
    logic [ICR_AW-1:0]    aw_addr;
    logic                 w_held;
    logic [ICR_DW-1:0]    wdata;
    logic [3:0]           wstrb;
    icr_bus_state_t       wst;
    logic [1:0]           bresp;
    icr_bus_state_t       rst;
    logic [ICR_DW-1:0]    rdata;
    logic [1:0]           rresp;
    logic                 alarm_prev;
  } icr_state_t;

  localparam icr_state_t ICR_STATE_RESET = '{
    cfg:        ICR_CFG_RESET,
    irq_status: ICR_EV_NONE,
    irq_mask:   ICR_EV_NONE,
    aw_held:    1'b0,
    aw_addr:    ICR_ADDR_CFG,
    w_held:     1'b0,
    wdata:      ICR_ZERO_WORD,
    wstrb:      ICR_ZERO_STRB,
    wst:        ICR_ST_IDLE,
    bresp:      ICR_RESP_OKAY,
    rst:        ICR_ST_IDLE,
    rdata:      ICR_ZERO_WORD,
    rresp:      ICR_RESP_OKAY,
    alarm_prev: 1'b0
  };

  icr_state_t            st;
  icr_state_t            next_st;
  logic                  aw_take;
  logic                  w_take;
  logic                  ar_take;
  logic                  do_write;
  logic [ICR_EV_N-1:0]   events;
  logic [ICR_CFG_W-1:0]  byte_mask;
  logic [ICR_CFG_W-1:0]  merged;
  icr_shape_cfg_t        shape_cfg;

  // Address and data are taken independently; a held one blocks only
  // its own channel, so the master may offer them in either order
  assign s_axi_awready = !st.aw_held && (st.wst == ICR_ST_IDLE);
  assign s_axi_wready  = !st.w_held && (st.wst == ICR_ST_IDLE);
  assign s_axi_arready = (st.rst == ICR_ST_IDLE);
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign do_write      = st.aw_held && st.w_held;

  // Byte lanes that cover the 16-bit register
  assign byte_mask = {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
  assign merged    = ((st.wdata[ICR_CFG_W-1:0] & byte_mask)
                     | (st.cfg & ~byte_mask)) & ICR_CFG_WMASK;

  // Events that set sticky status bits
  always_comb begin
    events = ICR_EV_NONE;
    if (do_write && st.aw_addr == ICR_ADDR_CFG) begin
      events[ICR_EV_CFG_WR] = 1'b1;
      if ((st.wdata[ICR_CFG_W-1:0] & byte_mask & ICR_CFG_RSVD) != '0) begin
        events[ICR_EV_RSVD_WR] = 1'b1;
      end
    end
    if (alarm_request && !st.alarm_prev) begin
      events[ICR_EV_ALARM] = 1'b1;
    end
  end

  // Next state: bus channels, register writes, read capture, interrupts
  always_comb begin
    next_st            = st;
    next_st.alarm_prev = alarm_request;

    // Write address and data capture
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end

    // Write execution once both halves are held
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.wst     = ICR_ST_ANSWER;
      next_st.bresp   = ICR_RESP_OKAY;
      case (st.aw_addr)
        ICR_ADDR_CFG: begin
          next_st.cfg = merged;
        end
        ICR_ADDR_MASK: begin
          if (st.wstrb[0]) begin
            next_st.irq_mask = st.wdata[ICR_EV_N-1:0];
          end
        end
        ICR_ADDR_STATUS: begin
          // Status is cleared only by reading it; writes are ignored
          next_st.bresp = ICR_RESP_OKAY;
        end
        default: begin
          next_st.bresp = ICR_RESP_SLVERR;
        end
      endcase
    end

    // Write response holds until taken
    if (st.wst == ICR_ST_ANSWER && s_axi_bready) begin
      next_st.wst = ICR_ST_IDLE;
    end

    // Read capture; a status read clears what it returned
    if (ar_take) begin
      next_st.rst   = ICR_ST_ANSWER;
      next_st.rresp = ICR_RESP_OKAY;
      next_st.rdata = ICR_ZERO_WORD;
      case (s_axi_araddr)
        ICR_ADDR_CFG: begin
          next_st.rdata[ICR_CFG_W-1:0] = st.cfg & ICR_CFG_WMASK;
        end
        ICR_ADDR_STATUS: begin
          next_st.rdata[ICR_EV_N-1:0] = st.irq_status;
          next_st.irq_status          = ICR_EV_NONE;
        end
        ICR_ADDR_MASK: begin
          next_st.rdata[ICR_EV_N-1:0] = st.irq_mask;
        end
        default: begin
          next_st.rresp = ICR_RESP_SLVERR;
        end
      endcase
    end else if (st.rst == ICR_ST_ANSWER && s_axi_rready) begin
      next_st.rst = ICR_ST_IDLE;
    end

    // New events win over a clearing read in the same cycle
    next_st.irq_status = next_st.irq_status | events;
  end

  // Single synchronous register for all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= ICR_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Bus outputs straight from state
  assign s_axi_bvalid = (st.wst == ICR_ST_ANSWER);
  assign s_axi_bresp  = st.bresp;
  assign s_axi_rvalid = (st.rst == ICR_ST_ANSWER);
  assign s_axi_rdata  = st.rdata;
  assign s_axi_rresp  = st.rresp;

  // Level interrupt while any unmasked status bit stands
  assign irq = |(st.irq_status & st.irq_mask);

  // Control levels decoded from the configuration word
  always_comb begin
    ctrl.offset_corr_enable    = st.cfg[ICR_B_OFFSET];
    ctrl.dual_channel_enable   = st.cfg[ICR_B_DUAL];
    // Die-id access owns the setup pins whenever it is enabled
    ctrl.four_pin_serial_setup_enable =
      st.cfg[ICR_B_FOUR_PIN] && !die_id_enable;
    ctrl.elastic_buffer_enable = st.cfg[ICR_B_BUFFER];
    ctrl.align_rx_power        = st.cfg[ICR_B_ALIGN_RX];
    ctrl.sync_rx_power         = st.cfg[ICR_B_SYNC_RX];
    ctrl.word_clock_rx_power   = st.cfg[ICR_B_WCLK_RX];
    ctrl.single_sync_mode      = st.cfg[ICR_B_SINGLE];
    // Read side follows the sync input only in single-sync mode
    ctrl.read_side_sync_from_sync = st.cfg[ICR_B_SINGLE];
  end

  // Alarm pin: enable low while driving, polarity chosen by software
  assign alarm_pin_oe_n = !st.cfg[ICR_B_ALARM_OE];
  assign alarm_pin_o    = st.cfg[ICR_B_ALARM_POL] ? alarm_request
                                                  : !alarm_request;

  // Shaper settings; buffer bypass does not touch them
  assign shape_cfg.width_sel       = st.cfg[ICR_B_WIDTH_HI:ICR_B_WIDTH_LO];
  assign shape_cfg.reverse         = st.cfg[ICR_B_REV];
  assign shape_cfg.twos_complement = st.cfg[ICR_B_TWOS];
  assign shape_cfg.full_word       = full_word_interface;

  // Input words are shaped one cycle after arrival
  icr_word_shaper u_shaper (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .cfg           (shape_cfg),
    .word_in       (input_word),
    .word_in_valid (input_word_valid),
    .sample        (shaped_sample),
    .sample_valid  (shaped_sample_valid)
  );

endmodule

// ==== hdl/icr_pkg.sv ====
// Package: register map, field positions and carrier types for the block
package icr_pkg;

  // Bus geometry
  localparam int          ICR_AW          = 8;
  localparam int          ICR_DW          = 32;
  localparam int          ICR_CFG_W       = 16;
  localparam int          ICR_WORD_W      = 14;
  localparam int          ICR_HALF_W      = 7;

  // Register byte addresses
  localparam logic [7:0]  ICR_ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ICR_ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ICR_ADDR_MASK   = 8'h08;

  // Configuration reset value and writable bits (8 and 1 stay zero)
  localparam logic [15:0] ICR_CFG_RESET   = 16'h44fc;
  localparam logic [15:0] ICR_CFG_WMASK   = 16'hfefd;
  localparam logic [15:0] ICR_CFG_RSVD    = 16'h0102;

  // Configuration field positions
  localparam int          ICR_B_OFFSET    = 15;
  localparam int          ICR_B_DUAL      = 14;
  localparam int          ICR_B_WIDTH_HI  = 13;
  localparam int          ICR_B_WIDTH_LO  = 12;
  localparam int          ICR_B_REV       = 11;
  localparam int          ICR_B_TWOS      = 10;
  localparam int          ICR_B_FOUR_PIN  = 9;
  localparam int          ICR_B_BUFFER    = 7;
  localparam int          ICR_B_ALARM_OE  = 6;
  localparam int          ICR_B_ALARM_POL = 5;
  localparam int          ICR_B_ALIGN_RX  = 4;
  localparam int          ICR_B_SYNC_RX   = 3;
  localparam int          ICR_B_WCLK_RX   = 2;
  localparam int          ICR_B_SINGLE    = 0;

  // Width field codes and the low bits each one discards
  localparam logic [1:0]  ICR_WIDTH_ALL   = 2'h0;
  localparam logic [1:0]  ICR_WIDTH_12    = 2'h1;
  localparam logic [13:0] ICR_KEEP_ALL    = 14'h3fff;
  localparam logic [13:0] ICR_KEEP_12     = 14'h3ffc;
  localparam logic [13:0] ICR_KEEP_10     = 14'h3ff0;

  // Interrupt event bits
  localparam int          ICR_EV_N        = 3;
  localparam int          ICR_EV_CFG_WR   = 0;
  localparam int          ICR_EV_RSVD_WR  = 1;
  localparam int          ICR_EV_ALARM    = 2;
  localparam logic [2:0]  ICR_EV_NONE     = 3'h0;

  // Bus responses and idle data
  localparam logic [1:0]  ICR_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  ICR_RESP_SLVERR = 2'h2;
  localparam logic [31:0] ICR_ZERO_WORD   = 32'h0000_0000;
  localparam logic [3:0]  ICR_ZERO_STRB   = 4'h0;
  localparam logic [13:0] ICR_ZERO_SAMPLE = 14'h0000;

  // Bus channel state, Gray along idle -> answer
  typedef enum logic [1:0] {
    ICR_ST_IDLE   = 2'b00,
    ICR_ST_ANSWER = 2'b01
  } icr_bus_state_t;

  // Control levels handed to the rest of the device
  typedef struct packed {
    logic offset_corr_enable;
    logic dual_channel_enable;
    logic four_pin_serial_setup_enable;
    logic elastic_buffer_enable;
    logic align_rx_power;
    logic sync_rx_power;
    logic word_clock_rx_power;
    logic single_sync_mode;
    logic read_side_sync_from_sync;
  } icr_ctrl_t;

  // Settings for the input word shaper
  typedef struct packed {
    logic [1:0] width_sel;
    logic       reverse;
    logic       twos_complement;
    logic       full_word;
  } icr_shape_cfg_t;

endpackage

// ==== hdl/icr_word_shaper.sv ====
// Input word shaper: bit reversal, coding and width selection
`timescale 1ns/10ps
module icr_word_shaper
  import icr_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire icr_shape_cfg_t        cfg,
  input  wire logic [ICR_WORD_W-1:0] word_in,
  input  wire logic                  word_in_valid,
  output logic      [ICR_WORD_W-1:0] sample,
  output logic                       sample_valid
);

  typedef struct packed {
    logic [ICR_WORD_W-1:0] sample;
    logic                  valid;
  } icr_shaper_state_t;

  icr_shaper_state_t             st;
  icr_shaper_state_t             next_st;
  logic [ICR_WORD_W-1:0]         rev_full;
  logic [ICR_WORD_W-1:0]         rev_half;
  logic [ICR_WORD_W-1:0]         ordered;
  logic [ICR_WORD_W-1:0]         coded;
  logic [ICR_WORD_W-1:0]         keep;

  // Both reversal forms per bit; halves swap only within themselves
  for (genvar i = 0; i < ICR_WORD_W; i++) begin : g_rev
    assign rev_full[i] = word_in[ICR_WORD_W-1-i];
    if (i < ICR_HALF_W) begin : g_lo
      assign rev_half[i] = word_in[ICR_HALF_W-1-i];
    end else begin : g_hi
      assign rev_half[i] = word_in[ICR_WORD_W-1-(i-ICR_HALF_W)];
    end
  end

  // Shaping runs whether or not the elastic buffer is in use
  always_comb begin
    next_st = st;
    if (!cfg.reverse) begin
      ordered = word_in;
    end else if (cfg.full_word) begin
      ordered = rev_full;
    end else begin
      ordered = rev_half;
    end
    // Offset binary becomes two's complement by flipping the sign bit
    coded = ordered;
    if (!cfg.twos_complement) begin
      coded[ICR_WORD_W-1] = ~ordered[ICR_WORD_W-1];
    end
    case (cfg.width_sel)
      ICR_WIDTH_ALL: keep = ICR_KEEP_ALL;
      ICR_WIDTH_12:  keep = ICR_KEEP_12;
      default:       keep = ICR_KEEP_10;
    endcase
    next_st.valid = word_in_valid;
    if (word_in_valid) begin
      next_st.sample = coded & keep;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '{sample: ICR_ZERO_SAMPLE, valid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign sample       = st.sample;
  assign sample_valid = st.valid;

endmodule

// ==== tb/icr_top_sva.sv ====
// Checker: port-level properties of the input path configuration block
`timescale 1ns/10ps
module icr_top_sva
  import icr_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        die_id_enable,
  input logic        alarm_request,
  input logic        alarm_pin_o,
  input logic        alarm_pin_oe_n,
  input logic        input_word_valid,
  input logic [13:0] shaped_sample,
  input logic        shaped_sample_valid,
  input icr_ctrl_t   ctrl
);
  default clocking cb @(posedge aclk); endclocking

  // Remembers whether the read in flight targets the configuration word
  logic rd_cfg;
  always_ff @(posedge aclk) begin
    if (!aresetn)
      rd_cfg <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready)
      rd_cfg <= (s_axi_araddr == ICR_ADDR_CFG);
  end

  // No disable here: it must look across the release of reset
  property p_reset_defaults;
    !aresetn ##1 aresetn |-> ctrl == icr_ctrl_t'(9'h0bc) && !s_axi_bvalid
      && !s_axi_rvalid && !alarm_pin_oe_n && alarm_pin_o == alarm_request;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("outputs after reset differ from defaults");

  property p_four_pin_prio;
    disable iff (!aresetn) die_id_enable |-> !ctrl.four_pin_serial_setup_enable;
  endproperty
  a_four_pin_prio: assert property (p_four_pin_prio)
    else $error("four pin mode active despite die id enable");

  property p_single_sync;
    disable iff (!aresetn)
      ctrl.single_sync_mode == ctrl.read_side_sync_from_sync;
  endproperty
  a_single_sync: assert property (p_single_sync)
    else $error("read side sync source disagrees with single sync mode");

  property p_sample_valid;
    disable iff (!aresetn) input_word_valid |=> shaped_sample_valid;
  endproperty
  a_sample_valid: assert property (p_sample_valid)
    else $error("shaped sample not valid one cycle after input");

  property p_sample_hold;
    disable iff (!aresetn) !input_word_valid |=> $stable(shaped_sample);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("shaped sample moved without input valid");

  property p_write_answer;
    disable iff (!aresetn) s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");

  property p_read_answer;
    disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data late");

  property p_read_stands;
    disable iff (!aresetn) s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_stands: assert property (p_read_stands)
    else $error("read data dropped before accepted");

  property p_rsvd_read;
    disable iff (!aresetn) s_axi_rvalid && rd_cfg |->
      !s_axi_rdata[8] && !s_axi_rdata[1] && s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved configuration bits read nonzero");
endmodule

// ==== tb/tb_icr_top.sv ====
// Testbench: register access, control levels, shaping and interrupts
`timescale 1ns/10ps
module tb_icr_top;
  import icr_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, die_id_enable, alarm_request;
  logic        full_word_interface, input_word_valid, alarm_pin_i;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq, alarm_pin_o, alarm_pin_oe_n;
  logic        shaped_sample_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [13:0] input_word, shaped_sample;
  icr_ctrl_t   ctrl;
  integer      seed, n_mismatch, checks;

  // Pad pulled high while the alarm pin floats
  assign alarm_pin_i = alarm_pin_oe_n ? 1'b1 : alarm_pin_o;

  icr_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .die_id_enable, .full_word_interface,
    .alarm_request, .alarm_pin_i, .alarm_pin_o, .alarm_pin_oe_n, .input_word,
    .input_word_valid, .shaped_sample, .shaped_sample_valid, .ctrl
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Ready goes up with the request; only the watchdog ends a stuck wait
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic icr_ctrl_t exp_ctrl(logic [15:0] c, logic die);
    return {c[15], c[14], c[9] & ~die, c[7], c[4], c[3], c[2], c[0], c[0]};
  endfunction

  // Reverse, then fix coding, then drop low bits by width
  function automatic logic [13:0] exp_shape(logic [13:0] w, logic [15:0] c,
                                            logic full);
    logic [13:0] r;
    r = w;
    for (int i = 0; i < 14; i++) begin
      if (c[11])
        r[i] = full ? w[13-i] : (i < 7 ? w[6-i] : w[20-i]);
    end
    if (!c[10]) r[13] = ~r[13];
    if (c[13]) return r & 14'h3ff0;
    if (c[12]) return r & 14'h3ffc;
    return r;
  endfunction

  initial begin
    logic [31:0] v, rd;
    logic [1:0]  rsp;
    seed = 13098;
    n_mismatch = 0;
    checks = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, die_id_enable, alarm_request, full_word_interface} = '0;
    {input_word_valid, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_wdata, s_axi_wstrb, input_word} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Defaults, then a single-lane write
    axi_read(ICR_ADDR_CFG, rd, rsp);
    check("cfg_reset", rd, 32'h0000_44fc);
    check("ctrl_reset", 32'(ctrl), 32'(exp_ctrl(16'h44fc, 1'b0)));
    axi_write(ICR_ADDR_CFG, 32'hffff_ffff, 4'h1, rsp);
    axi_read(ICR_ADDR_CFG, rd, rsp);
    check("cfg_lane0", rd, 32'h0000_44fd);
    $display("test reset_defaults done");
    // Every width, reversal and coding code, buffer on and off at random
    for (int i = 0; i < 32; i++) begin
      v = $random(seed);
      v[13:10] = i[3:0];
      if (i == 30) v[15:0] = 16'h0000;
      if (i == 31) v[15:0] = 16'hffff;
      axi_write(ICR_ADDR_CFG, v, 4'hf, rsp);
      axi_read(ICR_ADDR_CFG, rd, rsp);
      check("cfg_readback", rd, {16'h0000, v[15:0] & 16'hfefd});
      @(posedge aclk);
      die_id_enable <= 1'($random(seed));
      alarm_request <= 1'($random(seed));
      full_word_interface <= i[4];
      input_word <= 14'($random(seed));    // Word clock is aclk
      input_word_valid <= 1'b1;
      @(posedge aclk);
      input_word_valid <= 1'b0;
      #1;
      check("ctrl", 32'(ctrl), 32'(exp_ctrl(v[15:0], die_id_enable)));
      check("alarm_oe_n", 32'(alarm_pin_oe_n), 32'(!v[6]));
      v[31] = v[5] ? alarm_request : ~alarm_request;
      check("alarm_level", 32'(alarm_pin_o), 32'(v[31]));
      rd = 32'(exp_shape(input_word, v[15:0], i[4]));
      check("sample", 32'(shaped_sample), rd);
    end
    $display("test settings_sweep done");
    axi_write(8'h0c, 32'hffff_ffff, 4'hf, rsp);
    check("unmapped_wr", 32'(rsp), 32'(ICR_RESP_SLVERR));
    axi_read(8'h0c, rd, rsp);
    check("unmapped_rd", 32'(rsp), 32'(ICR_RESP_SLVERR));
    $display("test unmapped done");
    // Interrupt: clear, raise, mask, read out and clear again
    axi_write(ICR_ADDR_MASK, 32'h0000_0007, 4'hf, rsp);
    alarm_request <= 1'b0;
    axi_read(ICR_ADDR_STATUS, rd, rsp);
    repeat (2) @(posedge aclk);
    check("irq_clear", 32'(irq), 32'h0000_0000);
    axi_write(ICR_ADDR_CFG, 32'h0000_45fe, 4'hf, rsp);
    alarm_request <= 1'b1;
    @(posedge aclk);
    check("irq_set", 32'(irq), 32'h0000_0001);
    axi_write(ICR_ADDR_MASK, 32'h0000_0000, 4'hf, rsp);
    check("irq_masked", 32'(irq), 32'h0000_0000);
    axi_read(ICR_ADDR_STATUS, rd, rsp);
    check("status_events", rd, 32'h0000_0007);
    axi_read(ICR_ADDR_STATUS, rd, rsp);
    check("status_cleared", rd, 32'h0000_0000);
    $display("test interrupts done");
    // Reset in mid-run must bring back the defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ICR_ADDR_CFG, rd, rsp);
    check("cfg_rereset", rd, 32'h0000_44fc);
    check("sample_rereset", 32'(shaped_sample), 32'h0000_0000);
    $display("test mid_reset done");
    complete_run();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
endmodule

bind icr_top icr_top_sva u_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .die_id_enable, .alarm_request, .alarm_pin_o, .alarm_pin_oe_n,
  .input_word_valid, .shaped_sample, .shaped_sample_valid, .ctrl
);
